// ### include/hibg_pkg.sv
// Constants for the processor-side irq and bank glue block.
// Assumes 8-bit I/O addresses on the low address byte.
package hibg_pkg;
  // I/O offsets; reads and writes share some of them
  localparam logic [7:0] IO_CAP_CMD_LO = 8'h00;
  localparam logic [7:0] IO_CTL_A      = 8'h00;
  localparam logic [7:0] IO_CAP_CMD_HI = 8'h01;
  localparam logic [7:0] IO_CMD        = 8'h01;
  localparam logic [7:0] IO_CAP_BAR_LO = 8'h02;
  localparam logic [7:0] IO_CTL_B      = 8'h02;
  localparam logic [7:0] IO_CAP_BAR_HI = 8'h03;
  localparam logic [7:0] IO_IRQ        = 8'h04;
  localparam logic [7:0] IO_STATE      = 8'h05;
  localparam logic [7:0] IO_SHIFT      = 8'h06;

  // Interrupt sources and vectors
  localparam int         NUM_SRC       = 6;
  localparam int         SRC_CAPTURE   = 3;
  localparam int         SRC_WRAP      = 4;
  localparam logic [7:0] VEC_BASE      = 8'hf0;

  // Field positions
  localparam int CMD_CAPTURE_BIT = 0;
  localparam int CMD_HANDOFF_BIT = 1;
  localparam int CTLA_CLR_CAP    = 0;
  localparam int CTLA_CLR_WRAP   = 1;
  localparam int CTLB_BAR_EN     = 0;
  localparam int ST_READY_BIT    = 0;
  localparam int ST_CAP_BIT      = 1;
  localparam int ST_WRAP_BIT     = 2;

  // Widths and reset values
  localparam int          CNT_W     = 16;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [5:0]  RST_MASK  = 6'h00;
  localparam logic [15:0] RST_CNT   = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [7:0]  UNUSED_RD = 8'h00;
endpackage

// ### rtl/hibg_prio.sv
// Fixed-priority vector picker for the merged interrupt request.
// Assumes request bits already gated by their enables.
`timescale 1ns/100ps
module hibg_prio #(
  parameter int N = hibg_pkg::NUM_SRC
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [N-1:0] i_req,
  output logic              o_any,
  output logic [7:0]        o_vec
);
  typedef struct packed {
    logic       any;
    logic [7:0] vec;
  } hibg_prio_s;

  hibg_prio_s state_ff;
  hibg_prio_s nxt_state;

  ////////////////////////////////////////////////////////////////
  // Lowest index wins, so the loop runs downward
  always_comb begin
    logic [2:0] idx;
    idx = 3'h0;
    nxt_state.any = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (i_req[i]) begin
        idx = 3'(i);
        nxt_state.any = 1'b1;
      end
    end
    nxt_state.vec = hibg_pkg::VEC_BASE + {4'h0, idx, 1'b0};
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_any = state_ff.any;
  assign o_vec = state_ff.vec;
endmodule

// ### rtl/hibg_shift.sv
// Byte shift register shared by the processor and a serial sub-side.
// Assumes the sub-side clock is synchronous and slower than i_clk.
`timescale 1ns/100ps
module hibg_shift (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_load,
  input  wire logic [7:0] i_data,
  input  wire logic       i_handoff,
  input  wire logic       i_shift_clk,
  input  wire logic       i_shift_din,
  input  wire logic       i_shift_done,
  output logic [7:0]      o_byte,
  output logic            o_ready,
  output logic            o_dout
);
  typedef struct packed {
    logic [7:0] byte_q;
    logic       ready;
    logic       clk_prev;
  } hibg_shift_s;

  hibg_shift_s state_ff;
  hibg_shift_s nxt_state;

  ////////////////////////////////////////////////////////////////
  // Sub-side shifts on rising edge of its clock, MSB first
  always_comb begin
    nxt_state = state_ff;
    nxt_state.clk_prev = i_shift_clk;
    if (i_load) begin
      nxt_state.byte_q = i_data;
    end else if (i_shift_clk && !state_ff.clk_prev) begin
      nxt_state.byte_q = {state_ff.byte_q[6:0], i_shift_din};
    end
    // Set wins so a finished transfer is never lost
    if (i_handoff) begin
      nxt_state.ready = 1'b0;
    end
    if (i_shift_done) begin
      nxt_state.ready = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= '{byte_q: hibg_pkg::RST_BYTE, ready: 1'b1, clk_prev: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_byte  = state_ff.byte_q;
  assign o_ready = state_ff.ready;
  assign o_dout  = state_ff.byte_q[7];
endmodule

// ### rtl/hibg_top.sv
// Processor glue: I/O decode, merged interrupt with vectors, bank decode.
// Assumes bus strobes are synchronous to i_clk and last several cycles.
//
// Behaviour
// - I/O 0/1 read command capture low/high; write control a / command.
// - I/O 2/3 read barcode capture low/high; write 2 loads control b.
// - Write at I/O 4 sets six enables; read there gives status.
// - Enable bits: 0 power, 1 serial, 2 carrier, 3 capture, 4 wrap, 5 option.
// - Vectors F0,F2,F4,F6,F8,FA for sources 0 to 5.
// - Six sources merge into one request line.
// - Source 3 from capture flag, 4 from wrap flag, rest external.
// - A source requests only while its enable bit is set.
// - Non-maskable request is never asserted.
// - Four bank layouts chosen by bank-0 and active-low bank-2 selects.
// - Layout table: boot ROM, RAM or option ROM in low half; RAM or option ROM in high half.
// - Bank-2 high leaves only RAM and boot ROM layouts.
// - Lowest-numbered pending enabled source supplies the vector.
// - Vector driven during acknowledge cycle for third-state sampling.
// - Free-running counter overflow raises source 4.
`timescale 1ns/100ps
module hibg_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_iorq_n,
  input  wire logic        i_mreq_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic        i_m1_n,
  input  wire logic        i_src0_power_mgr,
  input  wire logic        i_src1_serial,
  input  wire logic        i_src2_carrier,
  input  wire logic        i_src5_option_unit,
  input  wire logic        i_barcode_trig,
  input  wire logic        i_bank0,
  input  wire logic        i_bank_sel_hi_n,
  input  wire logic        i_shift_clk,
  input  wire logic        i_shift_din,
  input  wire logic        i_shift_done,
  output logic [7:0]       o_data,
  output logic             o_data_oe_n,
  output logic             o_merged_irq_request_n,
  output logic             o_nmi_n,
  output logic             o_boot_rom_sel,
  output logic             o_dram_lo_sel,
  output logic             o_dram_hi_sel,
  output logic             o_opt_rom_lo_sel,
  output logic             o_opt_rom_hi_sel,
  output logic             o_shift_dout
);
  typedef struct packed {
    logic [7:0]                  ctl_a;
    logic [7:0]                  ctl_b;
    logic [7:0]                  cmd;
    logic [5:0]                  mask;
    logic [hibg_pkg::CNT_W-1:0]  cnt;
    logic [hibg_pkg::CNT_W-1:0]  cap_cmd;
    logic [hibg_pkg::CNT_W-1:0]  cap_bar;
    logic                        cap_flag;
    logic                        wrap_flag;
    logic                        wr_prev;
    logic                        bar_prev;
    logic [7:0]                  dout;
    logic                        oe_n;
    logic [4:0]                  sel;
    logic                        nmi_n;
    logic                        irq_n;
  } hibg_main_s;

  hibg_main_s state_ff;
  hibg_main_s nxt_state;

  logic [5:0] pend_w;
  logic [5:0] eff_w;
  logic       any_w;
  logic [7:0] vec_w;
  logic [7:0] shift_byte_w;
  logic       shift_ready_w;
  logic       io_wr;
  logic       io_wr_p;
  logic       io_rd;
  logic       ack;
  logic [7:0] io_a;

  ////////////////////////////////////////////////////////////////
  // Bus cycle qualifiers; acknowledge is IORQ with M1
  assign io_a    = i_addr[7:0];
  assign io_wr   = !i_iorq_n && !i_wr_n && i_m1_n;
  assign io_rd   = !i_iorq_n && !i_rd_n && i_m1_n;
  assign ack     = !i_iorq_n && !i_m1_n;
  assign io_wr_p = io_wr && !state_ff.wr_prev; // one write per strobe

  // Pending flags, same positions as enables
  assign pend_w = {i_src5_option_unit,
                   state_ff.wrap_flag,
                   state_ff.cap_flag,
                   i_src2_carrier,
                   i_src1_serial,
                   i_src0_power_mgr};
  assign eff_w  = pend_w & state_ff.mask;

  hibg_prio #(
    .N (hibg_pkg::NUM_SRC)
  ) u_prio (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_req   (eff_w),
    .o_any   (any_w),
    .o_vec   (vec_w)
  );

  hibg_shift u_shift (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_load       (io_wr_p && io_a == hibg_pkg::IO_SHIFT),
    .i_data       (i_data),
    .i_handoff    (io_wr_p && io_a == hibg_pkg::IO_CMD &&
                   i_data[hibg_pkg::CMD_HANDOFF_BIT]),
    .i_shift_clk  (i_shift_clk),
    .i_shift_din  (i_shift_din),
    .i_shift_done (i_shift_done),
    .o_byte       (shift_byte_w),
    .o_ready      (shift_ready_w),
    .o_dout       (o_shift_dout)
  );

  ////////////////////////////////////////////////////////////////
  // Next-state logic for registers, flags, read data and bank selects
  always_comb begin
    nxt_state          = state_ff;
    nxt_state.wr_prev  = io_wr;
    nxt_state.bar_prev = i_barcode_trig;
    nxt_state.nmi_n    = 1'b1;
    // Request kept in its own flop so the pin comes straight from a register
    nxt_state.irq_n    = !(|eff_w);
    nxt_state.cnt      = state_ff.cnt + 16'h0001;

    // Register writes
    if (io_wr_p) begin
      unique case (io_a)
        hibg_pkg::IO_CTL_A: nxt_state.ctl_a = i_data;
        hibg_pkg::IO_CMD:   nxt_state.cmd   = i_data;
        hibg_pkg::IO_CTL_B: nxt_state.ctl_b = i_data;
        hibg_pkg::IO_IRQ:   nxt_state.mask  = i_data[5:0];
        default: ;
      endcase
    end

    // Clears first, sets after, so a coinciding event wins
    if (io_wr_p && io_a == hibg_pkg::IO_CTL_A) begin
      if (i_data[hibg_pkg::CTLA_CLR_CAP]) begin
        nxt_state.cap_flag = 1'b0;
      end
      if (i_data[hibg_pkg::CTLA_CLR_WRAP]) begin
        nxt_state.wrap_flag = 1'b0;
      end
    end
    if (state_ff.cnt == hibg_pkg::CNT_MAX) begin
      nxt_state.wrap_flag = 1'b1;
    end

    // Command-triggered capture
    if (io_wr_p && io_a == hibg_pkg::IO_CMD &&
        i_data[hibg_pkg::CMD_CAPTURE_BIT]) begin
      nxt_state.cap_cmd  = state_ff.cnt;
      nxt_state.cap_flag = 1'b1;
    end
    // Barcode-triggered capture on rising edge when enabled
    if (i_barcode_trig && !state_ff.bar_prev &&
        state_ff.ctl_b[hibg_pkg::CTLB_BAR_EN]) begin
      nxt_state.cap_bar  = state_ff.cnt;
      nxt_state.cap_flag = 1'b1;
    end

    // Read data; vector during acknowledge, held for the whole cycle
    nxt_state.oe_n = 1'b1;
    nxt_state.dout = hibg_pkg::UNUSED_RD;
    if (ack) begin
      nxt_state.oe_n = 1'b0;
      nxt_state.dout = vec_w;
    end else if (io_rd) begin
      nxt_state.oe_n = 1'b0;
      unique case (io_a)
        hibg_pkg::IO_CAP_CMD_LO: nxt_state.dout = state_ff.cap_cmd[7:0];
        hibg_pkg::IO_CAP_CMD_HI: nxt_state.dout = state_ff.cap_cmd[15:8];
        hibg_pkg::IO_CAP_BAR_LO: nxt_state.dout = state_ff.cap_bar[7:0];
        hibg_pkg::IO_CAP_BAR_HI: nxt_state.dout = state_ff.cap_bar[15:8];
        hibg_pkg::IO_IRQ:        nxt_state.dout = {2'b00, pend_w};
        hibg_pkg::IO_STATE:      nxt_state.dout = {5'h00, state_ff.wrap_flag,
                                                   state_ff.cap_flag, shift_ready_w};
        hibg_pkg::IO_SHIFT:      nxt_state.dout = shift_byte_w;
        default: begin
          // Leave the bus to the other decoded chips
          nxt_state.oe_n = 1'b1;
        end
      endcase
    end

    // Bank decode, order: opt_hi opt_lo dram_hi dram_lo boot
    nxt_state.sel = 5'h00;
    if (!i_mreq_n) begin
      if (i_addr[15]) begin
        nxt_state.sel = i_bank_sel_hi_n ? 5'h04 : 5'h10;
      end else if (!i_bank0) begin
        nxt_state.sel = 5'h01;
      end else begin
        nxt_state.sel = i_bank_sel_hi_n ? 5'h02 : 5'h08;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= '{ctl_a: hibg_pkg::RST_BYTE, ctl_b: hibg_pkg::RST_BYTE,
                    cmd: hibg_pkg::RST_BYTE, mask: hibg_pkg::RST_MASK,
                    cnt: hibg_pkg::RST_CNT, cap_cmd: hibg_pkg::RST_CNT,
                    cap_bar: hibg_pkg::RST_CNT, cap_flag: 1'b0,
                    wrap_flag: 1'b0, wr_prev: 1'b0, bar_prev: 1'b0,
                    dout: hibg_pkg::UNUSED_RD, oe_n: 1'b1, sel: 5'h00,
                    nmi_n: 1'b1, irq_n: 1'b1};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_data                 = state_ff.dout;
  assign o_data_oe_n            = state_ff.oe_n;
  assign o_merged_irq_request_n = state_ff.irq_n;
  assign o_nmi_n                = state_ff.nmi_n;
  assign o_boot_rom_sel         = state_ff.sel[0];
  assign o_dram_lo_sel          = state_ff.sel[1];
  assign o_dram_hi_sel          = state_ff.sel[2];
  assign o_opt_rom_lo_sel       = state_ff.sel[3];
  assign o_opt_rom_hi_sel       = state_ff.sel[4];

  ////////////////////////////////////////////////////////////////
  // Checks beside the logic
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_nmi_held_off: assert property (o_nmi_n)
    else $error("nmi asserted");
  a_irq_needs_en: assert property (!o_merged_irq_request_n |-> $past(|eff_w))
    else $error("request without enabled source");
  a_irq_merge: assert property (|eff_w |=> !o_merged_irq_request_n)
    else $error("enabled source not merged");
  a_vec_top_prio: assert property (eff_w[0] |=> vec_w == 8'hf0)
    else $error("source 0 not preferred");
  a_vec_code: assert property (eff_w == 6'h20 |=> vec_w == 8'hfa)
    else $error("wrong vector for source 5");
  a_ack_vector: assert property (ack |=> !o_data_oe_n && o_data == $past(vec_w))
    else $error("vector not driven in acknowledge");
  a_mask_write: assert property (io_wr_p && io_a == 8'h04 |=>
                                 state_ff.mask == $past(i_data[5:0]))
    else $error("enable write lost");
  a_status_read: assert property (io_rd && !ack && io_a == 8'h04 |=>
                                  o_data == {2'b00, $past(pend_w)})
    else $error("status read wrong");
  a_cap_read: assert property (io_rd && !ack && io_a == 8'h00 |=>
                               o_data == $past(state_ff.cap_cmd[7:0]))
    else $error("capture low read wrong");
  // Command capture must show up as pending source 3 on the next cycle
  a_cap_source: assert property (io_wr_p && io_a == 8'h01 && i_data[0] |=> pend_w[3])
    else $error("capture flag not source 3");
  // Local request flop and the priority picker must agree
  a_irq_agree: assert property (o_merged_irq_request_n == !any_w)
    else $error("request and picker disagree");
  a_wrap_set: assert property (state_ff.cnt == 16'hffff |=> state_ff.wrap_flag)
    else $error("wrap flag not raised");
  a_bank_boot: assert property (!i_mreq_n && !i_addr[15] && !i_bank0 |=> o_boot_rom_sel)
    else $error("boot rom not selected");
  a_bank_opt_lo: assert property (!i_mreq_n && !i_addr[15] && i_bank0 && !i_bank_sel_hi_n
                                  |=> o_opt_rom_lo_sel)
    else $error("option low not selected");
  a_bank_pullup: assert property (i_bank_sel_hi_n |=> !o_opt_rom_lo_sel
                                  && !o_opt_rom_hi_sel)
    else $error("option rom reached with bank-2 high");

  c_ack_seen: cover property (ack && any_w);
  c_mask_write: cover property (io_wr_p && io_a == 8'h04);
  c_opt_bank: cover property (o_opt_rom_hi_sel);
  c_capture: cover property (state_ff.cap_flag && state_ff.mask[3]);
endmodule

// ### dv/hibg_cpu_model.sv
// Processor bus model: I/O write, I/O read, acknowledge and memory read cycles.
// Assumes the glue registers every answer one clock after it sees a strobe.
`timescale 1ns/100ps
module hibg_cpu_model (
  input  wire logic        i_clk,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_data_oe_n,
  input  wire logic [4:0]  i_sel,
  output logic      [15:0] o_addr,
  output logic      [7:0]  o_data,
  output logic             o_iorq_n,
  output logic             o_mreq_n,
  output logic             o_rd_n,
  output logic             o_wr_n,
  output logic             o_m1_n
);
  ////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    o_addr   = 16'h0000;
    o_data   = 8'h00;
    o_iorq_n = 1'b1;
    o_mreq_n = 1'b1;
    o_rd_n   = 1'b1;
    o_wr_n   = 1'b1;
    o_m1_n   = 1'b1;
  end

  // Release; address and data flip so a stale value never looks valid
  task automatic idle();
    o_iorq_n <= 1'b1;
    o_mreq_n <= 1'b1;
    o_rd_n   <= 1'b1;
    o_wr_n   <= 1'b1;
    o_m1_n   <= 1'b1;
    o_addr   <= ~o_addr;
    o_data   <= ~o_data;
  endtask

  // Write held for two edges; I/O space only, the model never writes memory
  task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr   <= {8'h00, a};
    o_data   <= d;
    o_iorq_n <= 1'b0;
    o_wr_n   <= 1'b0;
    repeat (2) @(posedge i_clk);
    idle();
  endtask

  // Kinds: 0 I/O read, 1 acknowledge, 2 memory read; answer taken at third edge
  task automatic cyc(input logic [1:0] k, input logic [15:0] a, output logic [7:0] d,
                     output logic oe_n, output logic [4:0] sel);
    @(posedge i_clk);
    o_addr   <= a;
    o_iorq_n <= (k == 2'h2);
    o_mreq_n <= (k != 2'h2);
    o_rd_n   <= (k == 2'h1);
    o_m1_n   <= (k != 2'h1);
    repeat (2) @(posedge i_clk);
    d    = i_data;
    oe_n = i_data_oe_n;
    sel  = i_sel;
    idle();
  endtask
endmodule

// ### dv/test_host_irq_and_bank_glue.sv
// Self-checking bench for the irq and bank glue, driven through the bus model.
// Assumes a 50 MHz clock and that the free-running counter starts at reset.
`timescale 1ns/100ps
module test_host_irq_and_bank_glue;
  logic        clk, rst_n, s0, s1, s2, s5, btrig, bank0, bank_hi_n;
  logic [15:0] addr, c1, c2;
  logic [7:0]  wdat, rdat, d;
  logic        iorq_n, mreq_n, rd_n, wr_n, m1_n, oe_n, irq_n, nmi_n, sdout, oe;
  logic [4:0]  sel, s;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          ta, tb, src;
  logic [7:0]  pm [4] = '{8'h3f, 8'h3e, 8'h3c, 8'h38};
  logic [7:0]  pv [4] = '{8'hf0, 8'hf2, 8'hf4, 8'hfa};

  hibg_top u_hibg_top (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_data(wdat),
    .i_iorq_n(iorq_n), .i_mreq_n(mreq_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_m1_n(m1_n),
    .i_src0_power_mgr(s0), .i_src1_serial(s1), .i_src2_carrier(s2),
    .i_src5_option_unit(s5), .i_barcode_trig(btrig), .i_bank0(bank0),
    .i_bank_sel_hi_n(bank_hi_n), .i_shift_clk(1'b0), .i_shift_din(1'b0),
    .i_shift_done(1'b0), .o_data(rdat), .o_data_oe_n(oe_n),
    .o_merged_irq_request_n(irq_n), .o_nmi_n(nmi_n), .o_boot_rom_sel(sel[4]),
    .o_dram_lo_sel(sel[3]), .o_dram_hi_sel(sel[2]), .o_opt_rom_lo_sel(sel[1]),
    .o_opt_rom_hi_sel(sel[0]), .o_shift_dout(sdout));

  hibg_cpu_model u_hibg_cpu_model (.i_clk(clk), .i_data(rdat), .i_data_oe_n(oe_n),
    .i_sel(sel), .o_addr(addr), .o_data(wdat), .o_iorq_n(iorq_n), .o_mreq_n(mreq_n),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_m1_n(m1_n));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the counter overflow run alone needs 65536 cycles
  initial clk = 1'b0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      bad_count++;
      $display("MISMATCH t=%0t timeout", $time);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string w);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, w, seen, exp);
    end
  endtask

  // Read with data and drive-enable compared together
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] k = 2'h0);
    u_hibg_cpu_model.cyc(k, {8'h00, a}, d, oe, s);
    check({7'h00, oe, d}, {8'h00, e}, "read or vector");
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    u_hibg_cpu_model.cyc(2'h0, {8'h00, a}, v[7:0], oe, s);
    u_hibg_cpu_model.cyc(2'h0, {8'h00, a + 8'h01}, v[15:8], oe, s);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_hibg_cpu_model.io_wr(a, v);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, s0, s1, s2, s5, btrig, bank0, bank_hi_n} = 8'h01;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({8'h00, nmi_n, irq_n, oe_n, sel}, 16'h00e0, "reset outputs");
    rd(8'h04, 8'h00);
    $display("test reset done");
    // Each external source alone, then masked
    for (int i = 0; i < 4; i++) begin
      src = (i < 3) ? i : 5;
      {s5, s2, s1, s0} <= 4'b0001 << i;
      wr(8'h04, 8'h01 << src);
      rd(8'h04, 8'h01 << src);
      check({15'h0, irq_n}, 16'h0000, "request low");
      rd(8'hf0 + 8'(2 * src), 8'hf0 + 8'(2 * src), 2'h1);
      wr(8'h04, ~(8'h01 << src) & 8'h3f);
      repeat (3) @(posedge clk);
      check({15'h0, irq_n}, 16'h0001, "masked source");
    end
    {s5, s2, s1, s0} <= 4'hf;
    for (int k = 0; k < 4; k++) begin
      wr(8'h04, pm[k]);
      rd(8'h00, pv[k], 2'h1);
    end
    wr(8'h04, 8'h00);
    {s5, s2, s1, s0} <= 4'h0;
    repeat (3) @(posedge clk);
    check({15'h0, irq_n}, 16'h0001, "all masked");
    $display("test sources done");
    // Barcode capture twice, spacing counted in clocks
    wr(8'h02, 8'h01);
    @(posedge clk);
    btrig <= 1'b1;
    ta = cycles;
    @(posedge clk);
    btrig <= 1'b0;
    rd16(8'h02, c1);
    @(posedge clk);
    btrig <= 1'b1;
    tb = cycles;
    @(posedge clk);
    btrig <= 1'b0;
    rd16(8'h02, c2);
    check(c2 - c1, 16'(tb - ta), "barcode spacing");
    // Command capture twice, nine clocks apart through the bus tasks
    wr(8'h01, 8'h01);
    rd16(8'h00, c1);
    wr(8'h01, 8'h01);
    rd16(8'h00, c2);
    check(c2 - c1, 16'h0009, "command spacing");
    rd(8'h04, 8'h08);
    wr(8'h04, 8'h08);
    rd(8'h00, 8'hf6, 2'h1);
    wr(8'h00, 8'h01);
    rd(8'h04, 8'h00);
    u_hibg_cpu_model.cyc(2'h0, 16'h0007, d, oe, s);
    check({15'h0, oe}, 16'h0001, "unmapped read");
    $display("test capture done");
    // Bank layouts: k[2] address top, k[1] bank-2 select, k[0] bank-0
    for (int k = 0; k < 8; k++) begin
      {bank_hi_n, bank0} <= 2'(k);
      u_hibg_cpu_model.cyc(2'h2, {k[2], 15'h1234}, d, oe, s);
      check({11'h0, s}, {11'h0, k[2] ? (k[1] ? 5'h04 : 5'h01)
            : (!k[0] ? 5'h10 : (k[1] ? 5'h08 : 5'h02))}, "bank select");
    end
    repeat (2) @(posedge clk);
    check({11'h0, sel}, 16'h0000, "selects idle");
    $display("test banks done");
    // Counter overflow raises source 4
    wr(8'h04, 8'h10);
    for (int n = 0; n < 70000 && irq_n !== 1'b0; n++) @(posedge clk);
    check({15'h0, irq_n}, 16'h0000, "overflow request");
    rd(8'h04, 8'h10);
    rd(8'h00, 8'hf8, 2'h1);
    wr(8'h00, 8'h02);
    rd(8'h04, 8'h00);
    check({15'h0, nmi_n}, 16'h0001, "nmi idle");
    // Shift byte and status port, flags now clear and ready still set
    wr(8'h06, 8'h81);
    rd(8'h06, 8'h81);
    check({15'h0, sdout}, 16'h0001, "shift msb out");
    rd(8'h05, 8'h01);
    $display("test overflow done");
    print_verdict();
  end
endmodule
